// [sslp_pkg.sv]
// Shared constants, rail map and carrier types of the sleep-state rail sequencer.
// Notes on behaviour
// - Request low powers down selected rails.
// - Request high powers sleep-disabled rails up.
// - First buck follows setting; others may reduce.
// - Second/fifth buck follow variant and setting.
// - Variant A: first turn-off within 100 us.
// - Variant A: off gap 0.5 to 3.0 ms.
// - Variant A: first turn-on within 100 us.
// - Variant A: on gap at most 1 ms.
// - Variant A: all rails good within 4.1 ms.
// - Variant B: ramp-down starts within 100 us.
// - Variant B: off gap 0.1 to 3.0 ms.
// - Variant B: third buck slews down 2.5-10 mV/us.
// - Variant B: ramp-up starts within 100 us.
// - Variant B: on gap at most 1 ms.
// - Variant B: second buck slews up 2.5-10 mV/us.
// - Variant B: third buck slews up 2.5-10 mV/us.
// - Early wake waits for power-down to finish.
package sslp_pkg;

  // ----------------------------------------------------------------
  // Rail map
  // ----------------------------------------------------------------
  localparam int RAIL_COUNT = 12;
  localparam int RAIL_IDX_W = 4;
  localparam int BUCK1 = 0;
  localparam int BUCK2 = 1;
  localparam int BUCK3 = 2;
  localparam int BUCK5 = 4;
  localparam int LDO4 = 9;
  localparam logic [RAIL_COUNT-1:0] ALWAYS_ON_MASK = 12'h200;
  // Default sleep-off sets: variant A turns the second buck off, variant B the fifth.
  localparam logic [RAIL_COUNT-1:0] DEFAULT_OFF_A = 12'h043;
  localparam logic [RAIL_COUNT-1:0] DEFAULT_OFF_B = 12'h051;
  localparam logic [RAIL_COUNT-1:0] RAIL_EN_RESET = 12'hfff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ENTRY_LAT_MAX_US = 100;
  localparam int EXIT_LAT_MAX_US = 100;
  localparam int A_OFF_GAP_MIN_US = 500;
  localparam int B_OFF_GAP_MIN_US = 100;
  localparam int OFF_GAP_MAX_US = 3000;
  localparam int ON_GAP_MAX_US = 1000;
  localparam int A_EXIT_TOTAL_MAX_US = 4100;
  localparam int GAP_W = 19;
  localparam int A_OFF_GAP_MIN_CYC = (A_OFF_GAP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int B_OFF_GAP_MIN_CYC = (B_OFF_GAP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_GAP_MAX_CYC = OFF_GAP_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int ON_GAP_MAX_CYC = ON_GAP_MAX_US * 1000 / CLK_PERIOD_NS;
  // Keeps a full reverse walk of every rail inside the total exit budget.
  localparam int A_ON_GAP_MAX_CYC = A_EXIT_TOTAL_MAX_US * 1000 / CLK_PERIOD_NS / RAIL_COUNT;
  localparam int ENTRY_LAT_MAX_CYC = ENTRY_LAT_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int EXIT_LAT_MAX_CYC = EXIT_LAT_MAX_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Voltage slewing
  // ----------------------------------------------------------------
  localparam int VCODE_W = 8;
  localparam int VSTEP_MV = 10;
  localparam int SLEW_MIN_MV_PER_US_X10 = 25;
  localparam int SLEW_MAX_MV_PER_US_X10 = 100;
  localparam int SLEW_STEP_MIN_NS = VSTEP_MV * 10000 / SLEW_MAX_MV_PER_US_X10;
  localparam int SLEW_STEP_MAX_NS = VSTEP_MV * 10000 / SLEW_MIN_MV_PER_US_X10;
  localparam int SLEW_STEP_NS = (SLEW_STEP_MIN_NS + SLEW_STEP_MAX_NS) / 2;
  localparam int SLEW_STEP_CYC = SLEW_STEP_NS / CLK_PERIOD_NS;
  localparam logic [VCODE_W-1:0] VCODE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic use_default;
    logic [RAIL_COUNT-1:0] off_mask;
    logic [RAIL_COUNT-1:0] reduce_mask;
  } sslp_cfg_t;

  typedef struct packed {
    logic [VCODE_W-1:0] boot_target_voltage;
    logic [VCODE_W-1:0] sleep_target_voltage;
  } sslp_vtarget_t;

  typedef enum logic [2:0] {
    ST_AWAKE   = 3'b000,
    ST_DN_STEP = 3'b001,
    ST_DN_GAP  = 3'b011,
    ST_ASLEEP  = 3'b010,
    ST_UP_STEP = 3'b110,
    ST_UP_GAP  = 3'b111
  } sslp_state_t;

endpackage

// [sslp_slew.sv]
// Voltage code ramp that moves one step per fixed interval toward a target.
module sslp_slew
  import sslp_pkg::*;
#(
  parameter int STEP_CYC = SLEW_STEP_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [VCODE_W-1:0] target_in,
  output logic [VCODE_W-1:0] code_out,
  output logic at_target_out
);

  logic [15:0] tick_ff;
  logic [VCODE_W-1:0] code_ff;

  // ----------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_ff <= 16'h0000;
    end else if (code_ff == target_in || tick_ff == 16'(STEP_CYC - 1)) begin
      tick_ff <= 16'h0000;
    end else begin
      tick_ff <= tick_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Code ramp
  // ----------------------------------------------------------------
  // One code per interval bounds the slew between the two rate limits.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_ff <= VCODE_RESET;
    end else if (tick_ff == 16'(STEP_CYC - 1) && code_ff != target_in) begin
      code_ff <= (code_ff < target_in) ? code_ff + 8'h01 : code_ff - 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      at_target_out <= 1'b0;
    end else begin
      at_target_out <= (code_ff == target_in);
    end
  end

  assign code_out = code_ff;

endmodule // sslp_slew

// [sslp_sequencer.sv]
// Top of the sleep-state rail sequencer: request sync, ordered rail switching and slew control.
module sslp_sequencer
  import sslp_pkg::*;
#(
  parameter logic [GAP_W-1:0] A_OFF_MIN_CYC = GAP_W'(A_OFF_GAP_MIN_CYC),
  parameter logic [GAP_W-1:0] B_OFF_MIN_CYC = GAP_W'(B_OFF_GAP_MIN_CYC),
  parameter logic [GAP_W-1:0] OFF_MAX_CYC = GAP_W'(OFF_GAP_MAX_CYC),
  parameter logic [GAP_W-1:0] ON_MAX_CYC = GAP_W'(ON_GAP_MAX_CYC),
  parameter logic [GAP_W-1:0] A_ON_MAX_CYC = GAP_W'(A_ON_GAP_MAX_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sleep_request_n_in,
  input wire logic variant_b_in,
  input wire sslp_cfg_t cfg_in,
  input wire logic [GAP_W-1:0] off_gap_cyc_in,
  input wire logic [GAP_W-1:0] on_gap_cyc_in,
  input wire sslp_vtarget_t buck2_vt_in,
  input wire sslp_vtarget_t buck3_vt_in,
  output logic [RAIL_COUNT-1:0] rail_en_out,
  output logic [RAIL_COUNT-1:0] rail_reduced_out,
  output logic [VCODE_W-1:0] buck2_vcode_out,
  output logic [VCODE_W-1:0] buck3_vcode_out,
  output logic asleep_out,
  output logic busy_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [GAP_W-1:0] clamp_gap(input logic [GAP_W-1:0] v,
                                                 input logic [GAP_W-1:0] lo,
                                                 input logic [GAP_W-1:0] hi);
    logic [GAP_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_b;
  logic req_meta_ff;
  logic req_n_ff;
  logic var_meta_ff;
  logic var_sync_ff;
  logic [1:0] strap_wait_ff;
  logic variant_b_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_b = rst_sync_ff[1];

  // The pin idles high, so reset shows an awake request.
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      req_meta_ff <= 1'b1;
      req_n_ff <= 1'b1;
    end else begin
      req_meta_ff <= sleep_request_n_in;
      req_n_ff <= req_meta_ff;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      var_meta_ff <= 1'b0;
      var_sync_ff <= 1'b0;
    end else begin
      var_meta_ff <= variant_b_in;
      var_sync_ff <= var_meta_ff;
    end
  end

  // The variant is a board strap: caught once so it cannot change mid-sequence.
  // The capture waits two edges after release, so that the synchroniser holds
  // the pin's level and not its own reset value.
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      strap_wait_ff <= 2'h0;
      variant_b_ff <= 1'b0;
    end else if (strap_wait_ff != 2'h3) begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      if (strap_wait_ff == 2'h2) begin
        variant_b_ff <= var_sync_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep selection
  // ----------------------------------------------------------------
  logic [RAIL_COUNT-1:0] off_sel;
  logic [RAIL_COUNT-1:0] reduce_sel;
  logic [GAP_W-1:0] off_gap;
  logic [GAP_W-1:0] on_gap;

  // The off set is read live at each step; only the reduce set is registered, when the synchronised request is first seen low.
  always_comb begin
    if (cfg_in.use_default) begin
      off_sel = variant_b_ff ? DEFAULT_OFF_B : DEFAULT_OFF_A;
    end else begin
      off_sel = cfg_in.off_mask;
    end
    off_sel = off_sel & ~ALWAYS_ON_MASK;
    reduce_sel = cfg_in.reduce_mask & ~off_sel;
  end

  always_comb begin
    if (variant_b_ff) begin
      off_gap = clamp_gap(off_gap_cyc_in, B_OFF_MIN_CYC, OFF_MAX_CYC);
      on_gap = clamp_gap(on_gap_cyc_in, GAP_W'(1), ON_MAX_CYC);
    end else begin
      off_gap = clamp_gap(off_gap_cyc_in, A_OFF_MIN_CYC, OFF_MAX_CYC);
      on_gap = clamp_gap(on_gap_cyc_in, GAP_W'(1), A_ON_MAX_CYC);
    end
  end

  // ----------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------
  sslp_state_t state_ff;
  sslp_state_t nxt_state;
  logic [RAIL_IDX_W-1:0] ptr_ff;
  logic [RAIL_IDX_W-1:0] up_idx;
  logic [RAIL_COUNT-1:0] slept_ff;
  logic [GAP_W-1:0] gap_ff;
  logic step_dn;
  logic step_up;

  assign up_idx = RAIL_IDX_W'(RAIL_COUNT - 1) - ptr_ff;
  assign step_dn = (state_ff == ST_DN_STEP) && (ptr_ff != RAIL_IDX_W'(RAIL_COUNT)) && off_sel[ptr_ff];
  assign step_up = (state_ff == ST_UP_STEP) && (ptr_ff != RAIL_IDX_W'(RAIL_COUNT)) && slept_ff[up_idx];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_AWAKE: begin
        if (!req_n_ff) begin
          nxt_state = ST_DN_STEP;
        end
      end
      ST_DN_STEP: begin
        if (ptr_ff == RAIL_IDX_W'(RAIL_COUNT)) begin
          nxt_state = ST_ASLEEP;
        end else if (step_dn) begin
          nxt_state = ST_DN_GAP;
        end
      end
      ST_DN_GAP: begin
        if (gap_ff == GAP_W'(0)) begin
          nxt_state = ST_DN_STEP;
        end
      end
      ST_ASLEEP: begin
        // A request that rose early is only seen here, after the last rail is down.
        if (req_n_ff) begin
          nxt_state = ST_UP_STEP;
        end
      end
      ST_UP_STEP: begin
        if (ptr_ff == RAIL_IDX_W'(RAIL_COUNT)) begin
          nxt_state = ST_AWAKE;
        end else if (step_up) begin
          nxt_state = ST_UP_GAP;
        end
      end
      ST_UP_GAP: begin
        if (gap_ff == GAP_W'(0)) begin
          nxt_state = ST_UP_STEP;
        end
      end
      default: begin
        nxt_state = ST_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_AWAKE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Rails that are not selected are skipped in one cycle each, so the first
  // switched rail follows the request by a few cycles only.
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ptr_ff <= '0;
    end else if (state_ff == ST_AWAKE || state_ff == ST_ASLEEP) begin
      ptr_ff <= '0;
    end else if ((state_ff == ST_DN_STEP || state_ff == ST_UP_STEP) && ptr_ff != RAIL_IDX_W'(RAIL_COUNT)) begin
      ptr_ff <= ptr_ff + RAIL_IDX_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      gap_ff <= '0;
    end else if (step_dn) begin
      gap_ff <= off_gap - GAP_W'(1);
    end else if (step_up) begin
      gap_ff <= on_gap - GAP_W'(1);
    end else if (gap_ff != GAP_W'(0)) begin
      gap_ff <= gap_ff - GAP_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Rail enables and voltage selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rail_en_out <= RAIL_EN_RESET;
      slept_ff <= '0;
    end else if (step_dn) begin
      rail_en_out[ptr_ff] <= 1'b0;
      slept_ff[ptr_ff] <= 1'b1;
    end else if (step_up) begin
      rail_en_out[up_idx] <= 1'b1;
      slept_ff[up_idx] <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rail_reduced_out <= '0;
    end else if (state_ff == ST_AWAKE && !req_n_ff) begin
      rail_reduced_out <= reduce_sel;
    end else if (state_ff == ST_ASLEEP && req_n_ff) begin
      rail_reduced_out <= '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      asleep_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      asleep_out <= (nxt_state == ST_ASLEEP);
      busy_out <= (nxt_state != ST_AWAKE) && (nxt_state != ST_ASLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Slewed rails
  // ----------------------------------------------------------------
  logic [VCODE_W-1:0] buck2_target;
  logic [VCODE_W-1:0] buck3_target;

  assign buck2_target = rail_reduced_out[BUCK2] ? buck2_vt_in.sleep_target_voltage : buck2_vt_in.boot_target_voltage;
  assign buck3_target = rail_reduced_out[BUCK3] ? buck3_vt_in.sleep_target_voltage : buck3_vt_in.boot_target_voltage;

  sslp_slew #(.STEP_CYC(SLEW_STEP_CYC)) u_buck2_slew (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .target_in(buck2_target),
    .code_out(buck2_vcode_out),
    .at_target_out()
  );

  sslp_slew #(.STEP_CYC(SLEW_STEP_CYC)) u_buck3_slew (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .target_in(buck3_target),
    .code_out(buck3_vcode_out),
    .at_target_out()
  );

endmodule // sslp_sequencer

// [sslp_sequencer_asserts.sv]
// Port-level assertions of the sleep-state rail sequencer, bound to its top.
module sslp_sequencer_asserts
  import sslp_pkg::*;
#(
  parameter logic [GAP_W-1:0] A_OFF_MIN_CYC = 19'd20,
  parameter logic [GAP_W-1:0] B_OFF_MIN_CYC = 19'd10,
  parameter logic [GAP_W-1:0] OFF_MAX_CYC = 19'd60,
  parameter logic [GAP_W-1:0] ON_MAX_CYC = 19'd40
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sleep_request_n_in,
  input wire logic variant_b_in,
  input wire logic [RAIL_COUNT-1:0] rail_en_out,
  input wire logic [RAIL_COUNT-1:0] rail_reduced_out,
  input wire logic [VCODE_W-1:0] buck2_vcode_out,
  input wire logic [VCODE_W-1:0] buck3_vcode_out,
  input wire logic asleep_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ------------------------------------------------------------
  // Gap tracking
  // ------------------------------------------------------------
  logic [RAIL_COUNT-1:0] prev_en_ff;
  logic [19:0] gap_ff;
  logic last_fall_ff;
  logic fall_chg;
  logic rise_chg;
  logic [19:0] off_min;
  // Margins leave room for the skip cycles spent on unselected rails.
  assign fall_chg = |(prev_en_ff & ~rail_en_out);
  assign rise_chg = |(~prev_en_ff & rail_en_out);
  assign off_min = (variant_b_in ? {1'b0, B_OFF_MIN_CYC} : {1'b0, A_OFF_MIN_CYC}) - 20'd2;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_en_ff <= RAIL_EN_RESET;
      gap_ff <= 20'h0;
      last_fall_ff <= 1'b0;
    end else begin
      prev_en_ff <= rail_en_out;
      if (fall_chg || rise_chg) begin
        gap_ff <= 20'h0;
        last_fall_ff <= fall_chg;
      end else if (gap_ff != 20'hfffff) begin
        gap_ff <= gap_ff + 20'h1;
      end
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  entry_start_a: assert property ($fell(sleep_request_n_in) && !busy_out && !asleep_out |->
    ##[1:4] busy_out ##[0:16] $changed(rail_en_out)) else $error("sleep entry did not start in time");
  exit_start_a: assert property ($rose(sleep_request_n_in) && asleep_out && !busy_out |->
    ##[1:6] !asleep_out ##[0:16] $changed(rail_en_out)) else $error("sleep exit did not start in time");
  off_gap_min_a: assert property (fall_chg && last_fall_ff |-> gap_ff >= off_min)
    else $error("turn-off gap too short");
  off_gap_max_a: assert property (fall_chg && last_fall_ff |-> gap_ff <= {1'b0, OFF_MAX_CYC} + 20'd16)
    else $error("turn-off gap too long");
  on_gap_max_a: assert property (rise_chg && !last_fall_ff |-> gap_ff <= {1'b0, ON_MAX_CYC} + 20'd16)
    else $error("turn-on gap too long");
  single_rail_a: assert property ($changed(rail_en_out) |-> $countones(rail_en_out ^ $past(rail_en_out)) == 1)
    else $error("more than one rail switched at once");
  ldo_kept_a: assert property (rail_en_out[LDO4]) else $error("always-on rail turned off");
  asleep_frozen_a: assert property (asleep_out ##1 asleep_out |-> $stable(rail_en_out))
    else $error("rail switched while asleep");
  reduce_clear_a: assert property ($fell(asleep_out) |-> ##[0:1] rail_reduced_out == '0)
    else $error("reduced rails not restored on wake");
  slew_step_a: assert property ($changed(buck2_vcode_out) |->
    (buck2_vcode_out - $past(buck2_vcode_out) == 8'h01) || ($past(buck2_vcode_out) - buck2_vcode_out == 8'h01))
    else $error("voltage code jumped");
  slew_pace_a: assert property ($changed(buck3_vcode_out) |=> $stable(buck3_vcode_out)[*8])
    else $error("voltage code stepped too fast");
  cover property ($rose(asleep_out));
  cover property ($fell(asleep_out));
  cover property ($rose(sleep_request_n_in) && busy_out && !asleep_out);
endmodule // sslp_sequencer_asserts

bind sslp_sequencer sslp_sequencer_asserts #(
  .A_OFF_MIN_CYC(A_OFF_MIN_CYC),
  .B_OFF_MIN_CYC(B_OFF_MIN_CYC),
  .OFF_MAX_CYC(OFF_MAX_CYC),
  .ON_MAX_CYC(ON_MAX_CYC)
) u_chk (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .sleep_request_n_in(sleep_request_n_in),
  .variant_b_in(variant_b_in),
  .rail_en_out(rail_en_out),
  .rail_reduced_out(rail_reduced_out),
  .buck2_vcode_out(buck2_vcode_out),
  .buck3_vcode_out(buck3_vcode_out),
  .asleep_out(asleep_out),
  .busy_out(busy_out)
);

// [sslp_host_model.sv]
// Behavioural host that publishes sleep settings and then drives the sleep request.
module sslp_host_model
  import sslp_pkg::*;
(
  input wire logic clk_in,
  input wire logic wants_sleep_in,
  input wire sslp_cfg_t cfg_in,
  output logic sleep_request_n_out,
  output sslp_cfg_t cfg_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic armed_q;
  initial begin
    sleep_request_n_out = 1'b1;
    cfg_out = '0;
    armed_q = 1'b0;
  end
  // Settings are frozen one cycle ahead of the request so the walk never sees them move.
  always @(posedge clk_in) begin
    if (!wants_sleep_in) begin
      sleep_request_n_out <= #1 1'b1;
      armed_q <= 1'b0;
    end else if (!armed_q) begin
      cfg_out <= #1 cfg_in;
      armed_q <= 1'b1;
    end else begin
      sleep_request_n_out <= #1 1'b0;
    end
  end
endmodule // sslp_host_model

// [sslp_sequencer_bench.sv]
// Self-checking bench of the sleep-state rail sequencer.
module sslp_sequencer_bench;
  import sslp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_b_in, variant_b_in, wants_sleep, req_n, asleep_out, busy_out, seen_asleep;
  sslp_cfg_t cfg_src, cfg_dut;
  sslp_vtarget_t vt2, vt3;
  logic [GAP_W-1:0] off_gap, on_gap;
  logic [RAIL_COUNT-1:0] rail_en_out, rail_reduced_out, exp_off;
  logic [VCODE_W-1:0] buck2_vcode_out, buck3_vcode_out;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  sslp_host_model host (.clk_in(clk_in), .wants_sleep_in(wants_sleep), .cfg_in(cfg_src),
    .sleep_request_n_out(req_n), .cfg_out(cfg_dut));
  sslp_sequencer #(.A_OFF_MIN_CYC(19'd20), .B_OFF_MIN_CYC(19'd10), .OFF_MAX_CYC(19'd60),
    .ON_MAX_CYC(19'd40), .A_ON_MAX_CYC(19'd30)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .sleep_request_n_in(req_n), .variant_b_in(variant_b_in), .cfg_in(cfg_dut),
    .off_gap_cyc_in(off_gap), .on_gap_cyc_in(on_gap), .buck2_vt_in(vt2), .buck3_vt_in(vt3),
    .rail_en_out(rail_en_out), .rail_reduced_out(rail_reduced_out), .buck2_vcode_out(buck2_vcode_out),
    .buck3_vcode_out(buck3_vcode_out), .asleep_out(asleep_out), .busy_out(busy_out));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (asleep_out === 1'b1) seen_asleep = 1'b1;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("ERROR run expected finish seen hang");
      report_and_stop();
    end
  end
  function automatic logic [RAIL_COUNT-1:0] off_set(input logic vb, input sslp_cfg_t c);
    logic [RAIL_COUNT-1:0] s;
    s = c.use_default ? (vb ? DEFAULT_OFF_B : DEFAULT_OFF_A) : c.off_mask;
    return s & ~ALWAYS_ON_MASK;
  endfunction
  task automatic chk_vec(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic settle(input logic want);
    int n;
    n = 0;
    while (!(asleep_out === want && busy_out === 1'b0) && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    #1;
    chk_bit("walk finished", 1'b1, n < 4000);
  endtask
  task automatic report_and_stop;
    $display("Checked %0d samples, %0d errors", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    variant_b_in = 1'b0;
    wants_sleep = 1'b0;
    cfg_src = '0;
    off_gap = '0;
    on_gap = '0;
    vt2 = '0;
    vt3 = '0;
    void'($urandom(90));
    for (int it = 0; it < 6; it++) begin
      rst_b_in = 1'b0;
      variant_b_in = it[0];
      vt2.boot_target_voltage = 8'h04 + 8'($urandom_range(3));
      vt2.sleep_target_voltage = vt2.boot_target_voltage - 8'($urandom_range(3));
      vt3.boot_target_voltage = 8'h04 + 8'($urandom_range(3));
      vt3.sleep_target_voltage = vt3.boot_target_voltage - 8'($urandom_range(3));
      cfg_src.use_default = (it < 2);
      cfg_src.off_mask = 12'($urandom) | (it == 5 ? 12'h003 : 12'h001);
      cfg_src.reduce_mask = 12'($urandom);
      // Gap corners: zero and all-ones exercise the clamps at both ends.
      off_gap = (it == 2) ? '0 : (it == 3 || it == 5) ? '1 : 19'($urandom_range(70));
      on_gap = (it == 2) ? '0 : (it == 3) ? '1 : 19'($urandom_range(50));
      repeat (5) @(posedge clk_in);
      #1;
      rst_b_in = 1'b1;
      seen_asleep = 1'b0;
      exp_off = off_set(variant_b_in, cfg_src);
      repeat (10) @(posedge clk_in);
      #1;
      wants_sleep = 1'b1;
      if (it == 5) begin
        repeat (30) @(posedge clk_in);
        #1;
        wants_sleep = 1'b0;
        settle(1'b0);
        chk_bit("early wake slept first", 1'b1, seen_asleep);
      end else begin
        settle(1'b1);
        chk_vec("rails asleep", ~exp_off, rail_en_out);
        chk_vec("reduced asleep", cfg_src.reduce_mask & ~exp_off, rail_reduced_out);
        wants_sleep = 1'b0;
        settle(1'b0);
      end
      chk_vec("rails awake", 12'hfff, rail_en_out);
      chk_vec("reduced awake", 12'h000, rail_reduced_out);
      // Up to seven codes may remain after wake, one interval each, plus a partly run interval.
      repeat (8 * SLEW_STEP_CYC) @(posedge clk_in);
      #1;
      chk_vec("buck2 code", {4'h0, vt2.boot_target_voltage}, {4'h0, buck2_vcode_out});
      chk_vec("buck3 code", {4'h0, vt3.boot_target_voltage}, {4'h0, buck3_vcode_out});
      $display("test %0d done, errors so far %0d", it, error_cnt);
    end
    report_and_stop();
  end
endmodule // sslp_sequencer_bench
